/* File: logic/tfpc_consts.vh */
`ifndef TFPC_CONSTS_VH
`define TFPC_CONSTS_VH
// Register byte offsets
`define TFPC_OFS_CTRL 12'h000
`define TFPC_OFS_STAT 12'h004
`define TFPC_OFS_MENU 12'h008
`define TFPC_OFS_EVT 12'h00c
// Control register fields
`define TFPC_CTRL_POST_DONE 0
`define TFPC_CTRL_LOADED 1
`define TFPC_CTRL_MOTION 2
`define TFPC_CTRL_CLEAN 3
`define TFPC_CTRL_FAULT 4
`define TFPC_CTRL_OP_BUSY 5
`define TFPC_CTRL_RANDOM 6
`define TFPC_CTRL_MAG1_AT 7
`define TFPC_CTRL_MAG2_AT 8
`define TFPC_CTRL_PREVENT 9
`define TFPC_CTRL_PRIO_RSV 10
`define TFPC_CTRL_POS_DONE 11
`define TFPC_CTRL_EJECTED 12
`define TFPC_CTRL_DIAG_DONE 13
`define TFPC_CTRL_MOVE_BUSY 14
`define TFPC_CTRL_RESET 32'h0000_0000
// Menu register fields
`define TFPC_MENU_CNT_LSB 0
`define TFPC_MENU_CNT_MSB 7
`define TFPC_MENU_ROWS 8'h04
`define TFPC_DISP_COLS 8'h10
// Event register bits (write one to clear)
`define TFPC_EVT_ENTER 0
`define TFPC_EVT_UNLOAD 1
`define TFPC_EVT_DIAG 2
`define TFPC_EVT_INV 3
`define TFPC_EVT_START 4
// Timing
`define TFPC_CLK_MHZ 250
`define TFPC_FLASH_MS 250
`define TFPC_LAMP_MS 1000
`define TFPC_FLASH_CYC (`TFPC_FLASH_MS * `TFPC_CLK_MHZ * 1000)
`define TFPC_LAMP_CYC (`TFPC_LAMP_MS * `TFPC_CLK_MHZ * 1000)
`define TFPC_DEB_CYC 16'h0100
`endif

/* File: logic/tfpc_panel.v */
// Design decisions made here: the AHB-Lite interface to the registers and the placing of the registers.
`include "tfpc_consts.vh"
module tfpc_panel #(
  parameter FLASH_CYC = `TFPC_FLASH_CYC,
  parameter LAMP_CYC = `TFPC_LAMP_CYC
) (
  input wire mclk_in,
  input wire reset_in,
  input wire hsel_in,
  input wire [11:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  output reg [31:0] hrdata_out,
  output reg hreadyout_out,
  output reg hresp_out,
  input wire unload_btn_in,
  input wire enter_btn_in,
  input wire down_btn_in,
  input wire up_btn_in,
  input wire mode_btn_in,
  input wire door_open_in,
  input wire prio_occupied_in,
  input wire mag1_present_in,
  input wire slot_last_empty_in,
  output reg led_activity_out,
  output reg led_clean_out,
  output reg led_service_out,
  output reg led_mag1_out,
  output reg led_mag2_out,
  output reg led_prio_out,
  output reg [1:0] marker_row_out,
  output reg plus_up_out,
  output reg plus_down_out,
  output reg service_mode_out,
  output reg offline_out,
  output reg rw_refuse_out,
  output reg transport_halt_out,
  output reg unit_attention_out,
  output reg rewind_req_out,
  output reg prio_load_out,
  output reg prio_use_ok_out
);
  localparam [4:0] ST_LAMP = 5'h01;
  localparam [4:0] ST_POST = 5'h02;
  localparam [4:0] ST_IDLE = 5'h04;
  localparam [4:0] ST_UNLOAD = 5'h08;
  localparam [4:0] ST_DIAG = 5'h10;

  reg [31:0] ctrl_r;
  reg [7:0] menu_cnt_r;
  reg [7:0] sel_r;
  reg [7:0] top_r;
  reg [4:0] evt_r;
  reg [4:0] st_r;
  reg [31:0] flash_cnt_r;
  reg flash_r;
  reg [31:0] lamp_cnt_r;
  reg seen_insert_r;
  reg loading_r;
  reg prio_seen_r;
  reg prio_pend_r;
  reg mode_req_r;
  reg door_q_r;
  reg [11:0] a_addr_r;
  reg a_wr_r;
  reg a_act_r;
  // Two-flop synchronisers for the nine button and sensor inputs; the bus inputs are not synchronised
  reg [8:0] sync1_r;
  reg [8:0] sync2_r;
  reg [8:0] prev_r;
  // Bit order: unload, enter, down, up, mode, door, prio cell, magazine 1, last slot
  wire [8:0] press = sync2_r & ~prev_r;
  wire press_mode = press[4];
  wire door_s = sync2_r[5];
  wire prio_s = sync2_r[6];
  wire mag1_s = sync2_r[7];
  wire slot_s = sync2_r[8];


  function [31:0] rd_mux;
    input [11:0] a;
    begin
      if (a == `TFPC_OFS_CTRL) begin
        rd_mux = ctrl_r;
      end else if (a == `TFPC_OFS_STAT) begin
        rd_mux = {19'h0, prio_seen_r, st_r, service_mode_out, marker_row_out, plus_up_out, plus_down_out,
          transport_halt_out, unit_attention_out};
      end else if (a == `TFPC_OFS_MENU) begin
        rd_mux = {16'h0, sel_r, menu_cnt_r};
      end else if (a == `TFPC_OFS_EVT) begin
        rd_mux = {27'h0, evt_r};
      end else begin
        rd_mux = 32'h0000_0000;
      end
    end
  endfunction

  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      sync1_r <= 9'h000;
      sync2_r <= 9'h000;
      prev_r <= 9'h000;
    end else begin
      sync1_r <= {slot_last_empty_in, mag1_present_in, prio_occupied_in, door_open_in, mode_btn_in,
        up_btn_in, down_btn_in, enter_btn_in, unload_btn_in};
      sync2_r <= sync1_r;
      prev_r <= sync2_r;
    end
  end

  // Shared flash divider so every flashing LED toggles in phase; the lamp timer is in the state machine
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      flash_cnt_r <= 32'h0;
      flash_r <= 1'b0;
    end else if (flash_cnt_r >= FLASH_CYC - 1) begin
      flash_cnt_r <= 32'h0;
      flash_r <= ~flash_r;
    end else begin
      flash_cnt_r <= flash_cnt_r + 32'h1;
    end
  end

  // Unload doubles as the diagnostic trigger while in service mode
  wire cmd_diag = press[0] & service_mode_out & ctrl_r[`TFPC_CTRL_LOADED];
  wire cmd_unload = press[0] & ~service_mode_out & ctrl_r[`TFPC_CTRL_LOADED];
  wire wr_evt = a_act_r & a_wr_r & (a_addr_r == `TFPC_OFS_EVT);
  wire busy_any = ctrl_r[`TFPC_CTRL_OP_BUSY] | (st_r != ST_IDLE);
  wire [7:0] sel_max = (menu_cnt_r == 8'h00) ? 8'h00 : menu_cnt_r - 8'h01;
  // A fresh load, as opposed to a cartridge that was already in the drive
  wire load_edge = ctrl_r[`TFPC_CTRL_LOADED] & ~seen_insert_r;

  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      st_r <= ST_LAMP;
      lamp_cnt_r <= 32'h0;
    end else begin
      case (st_r)
        ST_LAMP: begin
          lamp_cnt_r <= lamp_cnt_r + 32'h1;
          if (lamp_cnt_r >= LAMP_CYC - 1) begin
            st_r <= ST_POST;
          end
        end
        ST_POST: begin
          if (ctrl_r[`TFPC_CTRL_POST_DONE]) begin
            st_r <= ST_IDLE;
          end
        end
        ST_IDLE: begin
          if (cmd_diag) begin
            st_r <= ST_DIAG;
          end else if (cmd_unload) begin
            st_r <= ST_UNLOAD;
          end
        end
        ST_UNLOAD: begin
          if (ctrl_r[`TFPC_CTRL_EJECTED]) begin
            st_r <= ST_IDLE;
          end
        end
        ST_DIAG: begin
          if (ctrl_r[`TFPC_CTRL_DIAG_DONE]) begin
            st_r <= ST_IDLE;
          end
        end
        default: begin
          st_r <= ST_IDLE;
        end
      endcase
    end
  end

  // Bus slave, zero wait states; unmapped reads return zero
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      a_act_r <= 1'b0;
      a_wr_r <= 1'b0;
      a_addr_r <= 12'h000;
      ctrl_r <= `TFPC_CTRL_RESET;
      menu_cnt_r <= 8'h00;
      hrdata_out <= 32'h0;
      hreadyout_out <= 1'b1;
      hresp_out <= 1'b0;
    end else begin
      a_act_r <= hsel_in & htrans_in[1] & hready_in;
      a_wr_r <= hwrite_in;
      a_addr_r <= {haddr_in[11:2], 2'b00};
      if (hsel_in & htrans_in[1] & hready_in & ~hwrite_in) begin
        hrdata_out <= rd_mux({haddr_in[11:2], 2'b00});
      end
      if (a_act_r & a_wr_r) begin
        if (a_addr_r == `TFPC_OFS_CTRL) begin
          ctrl_r <= hwdata_in;
        end else if (a_addr_r == `TFPC_OFS_MENU) begin
          menu_cnt_r <= hwdata_in[`TFPC_MENU_CNT_MSB:`TFPC_MENU_CNT_LSB];
        end
      end
    end
  end

  // Menu marker and events; hardware set wins over software clear
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      sel_r <= 8'h00;
      top_r <= 8'h00;
      evt_r <= 5'h00;
      mode_req_r <= 1'b0;
      door_q_r <= 1'b0;
      prio_pend_r <= 1'b0;
      prio_seen_r <= 1'b0;
      seen_insert_r <= 1'b0;
      loading_r <= 1'b0;
    end else begin
      door_q_r <= door_s;
      if (press[2] && sel_r < sel_max) begin
        sel_r <= sel_r + 8'h01;
        if (sel_r + 8'h01 >= top_r + `TFPC_MENU_ROWS) begin
          top_r <= top_r + 8'h01;
        end
      end else if (press[3] && sel_r != 8'h00) begin
        sel_r <= sel_r - 8'h01;
        if (sel_r == top_r) begin
          top_r <= top_r - 8'h01;
        end
      end else if (sel_r > sel_max) begin
        sel_r <= sel_max;
        top_r <= 8'h00;
      end
      // A request lapses once service mode is in, so a later press means exit
      if (press_mode) begin
        mode_req_r <= ~service_mode_out;
      end else if (service_mode_out) begin
        mode_req_r <= 1'b0;
      end
      // Random mode leaves the cell to the host, so start is not latched there
      if (prio_s & ~prio_pend_r & ~ctrl_r[`TFPC_CTRL_RANDOM] & press[1]) begin
        prio_pend_r <= 1'b1;
      end else if (load_edge) begin
        prio_pend_r <= 1'b0;
      end
      if (sync2_r[6] | ctrl_r[`TFPC_CTRL_PRIO_RSV]) begin
        prio_seen_r <= 1'b1;
      end
      seen_insert_r <= ctrl_r[`TFPC_CTRL_LOADED];
      if (load_edge) begin
        loading_r <= 1'b1;
      end else if (ctrl_r[`TFPC_CTRL_POS_DONE] | ~ctrl_r[`TFPC_CTRL_LOADED]) begin
        loading_r <= 1'b0;
      end
      evt_r[`TFPC_EVT_ENTER] <= (press[1] & ~sync2_r[6]) | (evt_r[`TFPC_EVT_ENTER] &
        ~(wr_evt & hwdata_in[`TFPC_EVT_ENTER]));
      evt_r[`TFPC_EVT_UNLOAD] <= cmd_unload | (evt_r[`TFPC_EVT_UNLOAD] & ~(wr_evt & hwdata_in[`TFPC_EVT_UNLOAD]));
      evt_r[`TFPC_EVT_DIAG] <= cmd_diag | (evt_r[`TFPC_EVT_DIAG] & ~(wr_evt & hwdata_in[`TFPC_EVT_DIAG]));
      evt_r[`TFPC_EVT_INV] <= (door_s & ~door_q_r) | (evt_r[`TFPC_EVT_INV] &
        ~(wr_evt & hwdata_in[`TFPC_EVT_INV]));
      evt_r[`TFPC_EVT_START] <= (press[1] & sync2_r[6]) | (evt_r[`TFPC_EVT_START] &
        ~(wr_evt & hwdata_in[`TFPC_EVT_START]));
    end
  end

  // Outputs, all registered
  always @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) begin
      led_activity_out <= 1'b0;
      led_clean_out <= 1'b0;
      led_service_out <= 1'b0;
      led_mag1_out <= 1'b0;
      led_mag2_out <= 1'b0;
      led_prio_out <= 1'b0;
      marker_row_out <= 2'h0;
      plus_up_out <= 1'b0;
      plus_down_out <= 1'b0;
      service_mode_out <= 1'b0;
      offline_out <= 1'b0;
      rw_refuse_out <= 1'b0;
      transport_halt_out <= 1'b0;
      unit_attention_out <= 1'b0;
      rewind_req_out <= 1'b0;
      prio_load_out <= 1'b0;
      prio_use_ok_out <= 1'b0;
    end else begin
      if (st_r == ST_LAMP) begin
        led_service_out <= 1'b1;
        led_mag1_out <= 1'b1;
        led_mag2_out <= 1'b1;
        led_prio_out <= 1'b1;
        led_activity_out <= 1'b0;
        led_clean_out <= 1'b0;
      end else if (st_r == ST_POST) begin
        led_service_out <= flash_r;
        led_mag1_out <= flash_r;
        led_mag2_out <= flash_r;
        led_prio_out <= flash_r;
        led_activity_out <= 1'b0;
        led_clean_out <= 1'b0;
      end else begin
        if (ctrl_r[`TFPC_CTRL_FAULT]) begin
          led_service_out <= flash_r;
          led_activity_out <= flash_r;
          led_clean_out <= flash_r;
        end else if (st_r == ST_DIAG) begin
          led_service_out <= flash_r;
          led_activity_out <= ctrl_r[`TFPC_CTRL_MOTION];
          led_clean_out <= 1'b0;
        end else if (st_r == ST_UNLOAD) begin
          led_service_out <= 1'b0;
          led_activity_out <= flash_r;
          led_clean_out <= 1'b0;
        end else if (ctrl_r[`TFPC_CTRL_MOTION] | loading_r) begin
          led_service_out <= 1'b0;
          led_activity_out <= 1'b1;
          led_clean_out <= 1'b0;
        end else begin
          led_service_out <= 1'b0;
          led_activity_out <= 1'b0;
          led_clean_out <= ctrl_r[`TFPC_CTRL_CLEAN] & flash_r;
        end
        led_mag1_out <= ctrl_r[`TFPC_CTRL_MAG1_AT] |
          (ctrl_r[`TFPC_CTRL_RANDOM] & ctrl_r[`TFPC_CTRL_PREVENT]);
        led_mag2_out <= ctrl_r[`TFPC_CTRL_MAG2_AT] |
          (ctrl_r[`TFPC_CTRL_RANDOM] & ctrl_r[`TFPC_CTRL_PREVENT]);
        led_prio_out <= prio_seen_r & (sync2_r[6] | ctrl_r[`TFPC_CTRL_PRIO_RSV] | prio_pend_r);
      end
      // Entry deferred while busy_any (TFPC_CTRL_OP_BUSY or a non-idle state); exit is immediate
      if (service_mode_out & press_mode) begin
        service_mode_out <= 1'b0;
      end else if (mode_req_r & ~busy_any) begin
        service_mode_out <= 1'b1;
      end
      offline_out <= service_mode_out;
      rw_refuse_out <= service_mode_out;
      marker_row_out <= sel_r[1:0] - top_r[1:0];
      plus_up_out <= (top_r != 8'h00);
      plus_down_out <= (menu_cnt_r > top_r + `TFPC_MENU_ROWS);
      // Halt only once the move in flight has finished; release on close
      if (~door_s) begin
        transport_halt_out <= 1'b0;
      end else if (~ctrl_r[`TFPC_CTRL_MOVE_BUSY]) begin
        transport_halt_out <= 1'b1;
      end
      unit_attention_out <= evt_r[`TFPC_EVT_INV];
      rewind_req_out <= (st_r == ST_UNLOAD);
      prio_load_out <= prio_pend_r;
      // The cell needs magazine 1 and a free last slot in every library mode
      prio_use_ok_out <= mag1_s & slot_s;
    end
  end
endmodule // tfpc_panel

/* File: dv/tfpc_checker.sv */
module tfpc_checker #(
  parameter int FLASH_CYC = 4,
  parameter int LAMP_CYC = 8
) (
  input wire mclk_in,
  input wire reset_in,
  input wire hsel_in,
  input wire [11:0] haddr_in,
  input wire [1:0] htrans_in,
  input wire hwrite_in,
  input wire [2:0] hsize_in,
  input wire [31:0] hwdata_in,
  input wire hready_in,
  input wire [31:0] hrdata_out,
  input wire hreadyout_out,
  input wire hresp_out,
  input wire unload_btn_in,
  input wire enter_btn_in,
  input wire down_btn_in,
  input wire up_btn_in,
  input wire mode_btn_in,
  input wire door_open_in,
  input wire prio_occupied_in,
  input wire mag1_present_in,
  input wire slot_last_empty_in,
  input wire led_activity_out,
  input wire led_clean_out,
  input wire led_service_out,
  input wire led_mag1_out,
  input wire led_mag2_out,
  input wire led_prio_out,
  input wire [1:0] marker_row_out,
  input wire plus_up_out,
  input wire plus_down_out,
  input wire service_mode_out,
  input wire offline_out,
  input wire rw_refuse_out,
  input wire transport_halt_out,
  input wire unit_attention_out,
  input wire rewind_req_out,
  input wire prio_load_out,
  input wire prio_use_ok_out
);
  logic [7:0] cnt_r;
  // Saturates so a long run never wraps back into the power-up window
  always_ff @(posedge mclk_in or posedge reset_in) begin
    if (reset_in) cnt_r <= 8'h00;
    else if (cnt_r != 8'hff) cnt_r <= cnt_r + 8'h01;
  end
  default clocking @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  a_lamp_lit: assert property (
    cnt_r > 8'h02 && cnt_r < LAMP_CYC - 1 |-> led_service_out && led_mag1_out) else $error("lamp test dark");
  a_flash_phase: assert property (
    cnt_r > LAMP_CYC + 2 && cnt_r < 40 |-> led_service_out == led_mag1_out) else $error("flash out of phase");
  a_power_up_oper: assert property (
    $past(reset_in) |-> !service_mode_out) else $error("not in operator mode");
  a_service_offline: assert property (
    service_mode_out |=> offline_out && rw_refuse_out) else $error("service mode online");
  a_door_attention: assert property (
    $rose(door_open_in) |-> ##[1:8] unit_attention_out) else $error("no inventory alert");
  a_door_closed_run: assert property (
    !door_open_in [*5] |-> !transport_halt_out) else $error("halt with door closed");
  a_prio_use_ok: assert property (
    (mag1_present_in && slot_last_empty_in) [*5] |-> prio_use_ok_out) else $error("cell not usable");
  a_prio_use_block: assert property (
    !mag1_present_in [*5] |-> !prio_use_ok_out) else $error("cell usable without magazine");
  c_service: cover property ($rose(service_mode_out));
  c_rewind: cover property ($rose(rewind_req_out));
  c_attention: cover property ($rose(unit_attention_out));
endmodule // tfpc_checker

bind tfpc_panel tfpc_checker #(.FLASH_CYC(FLASH_CYC), .LAMP_CYC(LAMP_CYC)) tfpc_checker_i (.*);

/* File: dv/tfpc_operator.sv */
module tfpc_operator (
  input wire logic mclk_in,
  output logic [4:0] btn_out,
  output logic door_out,
  output logic prio_out,
  output logic mag1_out,
  output logic slot_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    btn_out = 5'h00;
    {door_out, prio_out, mag1_out, slot_out} = 4'h0;
  end
  // Held well past the two-flop sync so a press is never lost
  task press(input int b);
    @(posedge mclk_in) btn_out[b] <= 1'b1;
    repeat (4) @(posedge mclk_in);
    btn_out[b] <= 1'b0;
    repeat (6) @(posedge mclk_in);
  endtask
  task door_set(input logic v);
    @(posedge mclk_in) door_out <= v;
  endtask
  task stock(input logic v);
    @(posedge mclk_in) {mag1_out, slot_out} <= {v, v};
  endtask
  task place;
    @(posedge mclk_in) if (mag1_out && slot_out) prio_out <= 1'b1;
  endtask
endmodule // tfpc_operator

/* File: dv/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] ha = 12'h000;
  logic [1:0] ht = 2'b00;
  logic hw = 1'b0;
  logic [31:0] hwd = 32'h0000_0000;
  logic [31:0] q;
  logic hs = 1'b0;
  logic [2:0] hz = 3'b000;
  int err_count = 0;
  int samples_checked = 0;
  logic [7:0] a, c, s;
  wire [31:0] hrd;
  wire [1:0] mrow;
  wire [4:0] btn;
  wire hro, hre, act, cln, svc, m1, m2, pri, up, dn, svm, off, rfs, hlt, ua, rw, pld, pok, door, pocc, mag1, slot;
  initial forever #2 clk = ~clk;
  tfpc_operator tfpc_operator_i (.mclk_in(clk), .btn_out(btn), .door_out(door), .prio_out(pocc),
    .mag1_out(mag1), .slot_out(slot));
  tfpc_panel #(.FLASH_CYC(4), .LAMP_CYC(8)) tfpc_panel_i (.mclk_in(clk), .reset_in(rst), .hsel_in(hs),
    .haddr_in(ha), .htrans_in(ht), .hwrite_in(hw), .hsize_in(hz), .hwdata_in(hwd), .hready_in(hro),
    .hrdata_out(hrd), .hreadyout_out(hro), .hresp_out(hre), .unload_btn_in(btn[0]), .enter_btn_in(btn[1]),
    .down_btn_in(btn[2]), .up_btn_in(btn[3]), .mode_btn_in(btn[4]), .door_open_in(door),
    .prio_occupied_in(pocc), .mag1_present_in(mag1), .slot_last_empty_in(slot), .led_activity_out(act),
    .led_clean_out(cln), .led_service_out(svc), .led_mag1_out(m1), .led_mag2_out(m2), .led_prio_out(pri),
    .marker_row_out(mrow), .plus_up_out(up), .plus_down_out(dn), .service_mode_out(svm), .offline_out(off),
    .rw_refuse_out(rfs), .transport_halt_out(hlt), .unit_attention_out(ua), .rewind_req_out(rw),
    .prio_load_out(pld), .prio_use_ok_out(pok));
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task bus(input logic w, input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    hs <= 1'b1;
    hz <= 3'b010;
    ha <= ad;
    ht <= 2'b10;
    hw <= w;
    do @(posedge clk); while (hro !== 1'b1);
    hs <= 1'b0;
    ht <= 2'b00;
    hwd <= d;
    do @(posedge clk); while (hro !== 1'b1);
    q = hrd;
  endtask
  task chk(input logic [31:0] sv, input logic [31:0] ev);
    samples_checked++;
    if (sv !== ev) begin
      err_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, sv, ev);
    end
  endtask
  // Two whole flash periods, so the count is phase independent
  task fl;
    a = 0;
    c = 0;
    s = 0;
    repeat (16) begin
      @(posedge clk);
      a += act;
      c += cln;
      s += svc;
    end
  endtask
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", err_count, samples_checked);
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    wt(5000);
    err_count++;
    report_and_stop;
  end
  initial begin
    wt(5);
    rst <= 1'b0;
    bus(0, 12'h000, 0);
    chk(q, 32'h0);
    chk({hro, hre}, 2'b10);
    bus(0, 12'h010, 0);
    chk(q, 32'h0);
    wt(4);
    bus(0, 12'h004, 0);
    chk(q[11:7], 5'h02);
    wt(30);
    bus(1, 12'h000, 32'h1);
    wt(4);
    chk({svc, pri}, 2'b00);
    bus(1, 12'h000, 32'h7);
    wt(3);
    chk(act, 1);
    bus(1, 12'h000, 32'h9);
    wt(3);
    fl;
    chk({a[7:0], c[7:0], s[7:0]}, 24'h000800);
    bus(1, 12'h000, 32'h11);
    wt(3);
    fl;
    chk({a[7:0], c[7:0], s[7:0]}, 24'h080808);
    bus(1, 12'h000, 32'h3);
    tfpc_operator_i.press(0);
    fl;
    chk({rw, a[7:0]}, 9'h108);
    bus(1, 12'h000, 32'h1001);
    wt(4);
    chk({rw, act}, 2'b00);
    bus(1, 12'h000, 32'h81);
    wt(3);
    chk({m1, m2}, 2'b10);
    bus(1, 12'h000, 32'h241);
    wt(3);
    chk({m1, m2}, 2'b11);
    bus(1, 12'h008, 32'h6);
    wt(3);
    chk({up, dn}, 2'b01);
    tfpc_operator_i.press(3);
    bus(0, 12'h008, 0);
    chk(q[15:8], 8'h00);
    repeat (6) tfpc_operator_i.press(2);
    bus(0, 12'h008, 0);
    chk({q[15:8], up, dn}, 10'h016);
    chk(mrow, 2'h3);
    tfpc_operator_i.press(1);
    bus(0, 12'h00c, 0);
    chk(q[0], 1);
    bus(1, 12'h00c, 32'h1f);
    bus(1, 12'h000, 32'h1);
    tfpc_operator_i.door_set(1);
    wt(8);
    chk({hlt, ua}, 2'b11);
    tfpc_operator_i.door_set(0);
    wt(8);
    chk(hlt, 0);
    bus(1, 12'h00c, 32'h8);
    wt(2);
    chk(ua, 0);
    bus(1, 12'h000, 32'h23);
    tfpc_operator_i.press(4);
    chk(svm, 0);
    chk(act, 1);
    bus(1, 12'h000, 32'h803);
    wt(6);
    chk({svm, off, rfs}, 3'b111);
    chk(act, 0);
    tfpc_operator_i.press(0);
    bus(0, 12'h004, 0);
    chk(q[11:6], 6'h21);
    fl;
    chk(s, 8);
    bus(1, 12'h000, 32'h2003);
    tfpc_operator_i.press(4);
    chk({svm, off}, 2'b00);
    tfpc_operator_i.stock(1);
    wt(6);
    chk(pok, 1);
    tfpc_operator_i.place;
    wt(5);
    chk(pri, 1);
    tfpc_operator_i.press(1);
    bus(0, 12'h00c, 0);
    chk({q[4], pld}, 2'b11);
    bus(1, 12'h000, 32'h2001);
    bus(1, 12'h000, 32'h2043);
    wt(3);
    chk(pld, 0);
    tfpc_operator_i.press(1);
    chk({pld, pok}, 2'b01);
    report_and_stop;
  end
endmodule // tb_top
